// [logic/did_pkg.sv]
/*
 * Constants for the digital input debounce and edge counter block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
`default_nettype none

package did_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_THRESHOLD_SETUP = 4'h0;
   localparam logic [3:0] ADDR_INPUT_CONFIG = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_EDGE_COUNT = 4'hC;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int THR_CODE_LSB = 0;
   localparam int THR_REFSEL_BIT = 8;
   localparam int CFG_DBTIME_LSB = 0;
   localparam int CFG_STYLE_BIT = 5;
   localparam int CFG_INVERT_BIT = 6;
   localparam int CFG_COUNTEN_BIT = 7;
   localparam int CFG_SINKRANGE_BIT = 8;
   localparam int CFG_SINKCODE_LSB = 9;
   localparam int CFG_OUTSEL_LSB = 16;
   localparam int STAT_STATE_BIT = 0;
   localparam int STAT_SAMPLE_BIT = 1;
   localparam logic [31:0] THRESHOLD_SETUP_RESET = 32'h0000_0000;
   localparam logic [31:0] INPUT_CONFIG_RESET = 32'h0000_0000;
   localparam logic [31:0] THRESHOLD_SETUP_MASK = 32'h0000_011F;
   localparam logic [31:0] INPUT_CONFIG_MASK = 32'h0003_3FFF;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned SAMPLE_PERIOD_NS = 800;
   localparam int unsigned SAMPLE_TICK_CYCLES =
      SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int DB_CNT_W = 17;

   // debounce durations in ns for codes 01..1F
   localparam int unsigned DEBOUNCE_NS [1:31] = '{
      13000, 18700, 24400, 32500, 42300, 56100, 75600, 100800,
      130100, 180500, 240600, 320300, 420300, 560200, 750400,
      1000800, 1300800, 1800800, 2400800, 3200800, 4200800,
      5600800, 7500700, 10000700, 13000700, 18000600, 24000600,
      32000500, 42000400, 56000300, 75000000};

   // output pin source select
   typedef enum logic [1:0] {
      DID_OUT_LOW = 2'b00,
      DID_OUT_HIGH = 2'b01,
      DID_OUT_DEBOUNCED = 2'b10,
      DID_OUT_SAMPLE = 2'b11
   } did_outsel_t;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

`default_nettype wire

// [logic/did_top.sv]
/*
 * One digital input channel: comparator synchroniser, periodic sampler,
 * two debounce algorithms, polarity inverter, 32-bit edge counter,
 * output pin source select and an AXI4-Lite register slave.
 * Assumes the comparator output is asynchronous to aclk and that the
 * analog threshold DAC and current sink consume the config outputs.
 */
// Decided for this implementation: the address map and register access over AXI4-Lite.
`default_nettype none

module did_top #(
   // ns per debounce count; raise it in simulation to shorten waits
   parameter int unsigned TIME_SCALE_NS = did_pkg::SAMPLE_PERIOD_NS
) (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [3:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [3:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // comparator side
   input wire logic comp_out_async,
   output logic [4:0] threshold_code,
   output logic threshold_reference_select,
   output logic sink_range,
   output logic [4:0] sink_code,
   // channel output pin
   output logic channel_output_pin
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // byte-lane merge of a write into a register, reserved bits forced 0
   function automatic logic [31:0] merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb,
      input logic [31:0] mask);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r & mask;
   endfunction

   // debounce target in samples, rounded up, never below one
   function automatic logic [did_pkg::DB_CNT_W-1:0] target_of(
      input logic [4:0] code);
      int unsigned t;
      t = 1;
      if (code != 5'h00) begin
         t = (did_pkg::DEBOUNCE_NS[code] + TIME_SCALE_NS - 1) /
             TIME_SCALE_NS;
      end
      if (t == 0) begin
         t = 1;
      end
      return t[did_pkg::DB_CNT_W-1:0];
   endfunction

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   logic aw_held, next_aw_held;
   logic w_held, next_w_held;
   logic [3:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic [31:0] thr_reg, next_thr_reg;
   logic [31:0] cfg_reg, next_cfg_reg;
   logic [31:0] edge_count;
   logic input_state, sample_bit;

   // ready outputs are combinational; one write and one read at a time;
   // ce gates them so no item is handed over while the flops are frozen
   assign awready = ce && !aw_held && !bvalid;
   assign wready = ce && !w_held && !bvalid;
   assign arready = ce && !rvalid;

   // write path waits for both address and data, then commits once
   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_thr_reg = thr_reg;
      next_cfg_reg = cfg_reg;
      if (awvalid && awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_w_held = 1'b1;
         next_w_data = wdata;
         next_w_strb = wstrb;
      end
      if (aw_held && w_held && !bvalid) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = did_pkg::RESP_OKAY;
         case (aw_addr)
            did_pkg::ADDR_THRESHOLD_SETUP: begin
               next_thr_reg = merge(thr_reg, w_data, w_strb,
                  did_pkg::THRESHOLD_SETUP_MASK);
            end
            did_pkg::ADDR_INPUT_CONFIG: begin
               next_cfg_reg = merge(cfg_reg, w_data, w_strb,
                  did_pkg::INPUT_CONFIG_MASK);
            end
            // status and count are read-only: ignored, answered okay
            did_pkg::ADDR_STATUS, did_pkg::ADDR_EDGE_COUNT: begin
               next_bresp = did_pkg::RESP_OKAY;
            end
            default: begin
               next_bresp = did_pkg::RESP_SLVERR;
            end
         endcase
      end else if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
   end

   // read path answers one cycle after the address is taken
   always_comb begin
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp = did_pkg::RESP_OKAY;
         next_rdata = 32'h0000_0000;
         case (araddr)
            did_pkg::ADDR_THRESHOLD_SETUP: next_rdata = thr_reg;
            did_pkg::ADDR_INPUT_CONFIG: next_rdata = cfg_reg;
            did_pkg::ADDR_STATUS: begin
               next_rdata[did_pkg::STAT_STATE_BIT] = input_state;
               next_rdata[did_pkg::STAT_SAMPLE_BIT] = sample_bit;
            end
            did_pkg::ADDR_EDGE_COUNT: next_rdata = edge_count;
            default: next_rresp = did_pkg::RESP_SLVERR;
         endcase
      end else if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
   end

   // bus and register state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= did_pkg::RESP_OKAY;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= did_pkg::RESP_OKAY;
         thr_reg <= did_pkg::THRESHOLD_SETUP_RESET;
         cfg_reg <= did_pkg::INPUT_CONFIG_RESET;
      end else if (ce) begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
         thr_reg <= next_thr_reg;
         cfg_reg <= next_cfg_reg;
      end
   end

   // ----------------------------------------------------------------
   // configuration fields
   // ----------------------------------------------------------------
   logic [4:0] db_time;
   logic db_style, invert_en, count_en;
   logic [1:0] out_sel;

   // codes are passed as written: range limits per reference are the
   // software's to keep, the hardware does not clamp them
   assign threshold_code = thr_reg[did_pkg::THR_CODE_LSB +: 5];
   assign threshold_reference_select =
      thr_reg[did_pkg::THR_REFSEL_BIT];
   assign sink_range = cfg_reg[did_pkg::CFG_SINKRANGE_BIT];
   assign sink_code = cfg_reg[did_pkg::CFG_SINKCODE_LSB +: 5];
   assign db_time = cfg_reg[did_pkg::CFG_DBTIME_LSB +: 5];
   assign db_style = cfg_reg[did_pkg::CFG_STYLE_BIT];
   assign invert_en = cfg_reg[did_pkg::CFG_INVERT_BIT];
   assign count_en = cfg_reg[did_pkg::CFG_COUNTEN_BIT];
   assign out_sel = cfg_reg[did_pkg::CFG_OUTSEL_LSB +: 2];

   // ----------------------------------------------------------------
   // synchroniser and sampler
   // ----------------------------------------------------------------
   logic sync_a, sync_b;
   logic [2:0] tick_cnt, next_tick_cnt;
   logic tick;
   logic next_sample_bit;

   // the first flop feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end else if (ce) begin
         sync_a <= comp_out_async;
         sync_b <= sync_a;
      end
   end

   // sample strobe once per sample period
   assign tick = (tick_cnt ==
      3'(did_pkg::SAMPLE_TICK_CYCLES - 1));

   always_comb begin
      next_tick_cnt = tick ? 3'h0 : tick_cnt + 3'h1;
      next_sample_bit = tick ? sync_b : sample_bit;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt <= 3'h0;
         sample_bit <= 1'b0;
      end else if (ce) begin
         tick_cnt <= next_tick_cnt;
         sample_bit <= next_sample_bit;
      end
   end

   // ----------------------------------------------------------------
   // debounce
   // ----------------------------------------------------------------
   logic db_state, next_db_state;
   logic [did_pkg::DB_CNT_W-1:0] db_cnt, next_db_cnt, db_target;
   logic differ;

   assign db_target = target_of(db_time);
   assign differ = (sync_b != db_state);

   // only sampled values move the debouncer; counter saturates at zero
   always_comb begin
      next_db_state = db_state;
      next_db_cnt = db_cnt;
      if (tick) begin
         if (db_time == 5'h00) begin
            next_db_state = sync_b;
            next_db_cnt = '0;
         end else if (differ) begin
            if (db_cnt + 1'b1 >= db_target) begin
               next_db_state = sync_b;
               next_db_cnt = '0;
            end else begin
               next_db_cnt = db_cnt + 1'b1;
            end
         end else if (!db_style) begin
            if (db_cnt != '0) begin
               next_db_cnt = db_cnt - 1'b1;
            end
         end else begin
            next_db_cnt = '0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         db_state <= 1'b0;
         db_cnt <= '0;
      end else if (ce) begin
         db_state <= next_db_state;
         db_cnt <= next_db_cnt;
      end
   end

   // ----------------------------------------------------------------
   // inverter, edge counter, output pin
   // ----------------------------------------------------------------
   logic prev_state, next_prev_state;
   logic [31:0] next_edge_count;
   logic next_pin;

   assign input_state = db_state ^ invert_en;

   // rising edges of the inverted view are falling debounced edges
   always_comb begin
      next_prev_state = input_state;
      next_edge_count = edge_count;
      if (count_en && input_state && !prev_state) begin
         next_edge_count = edge_count + 32'h0000_0001;
      end
      // count_en low leaves the count untouched
      case (did_pkg::did_outsel_t'(out_sel))
         did_pkg::DID_OUT_LOW: next_pin = 1'b0;
         did_pkg::DID_OUT_HIGH: next_pin = 1'b1;
         did_pkg::DID_OUT_DEBOUNCED: next_pin = input_state;
         did_pkg::DID_OUT_SAMPLE: next_pin = sample_bit;
         default: next_pin = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_state <= 1'b0;
         edge_count <= 32'h0000_0000;
         channel_output_pin <= 1'b0;
      end else if (ce) begin
         prev_state <= next_prev_state;
         edge_count <= next_edge_count;
         channel_output_pin <= next_pin;
      end
   end

endmodule

`default_nettype wire

// [tb/did_sensor.sv]
/*
 * Field sensor model: drives the comparator output of one channel.
 * Assumes the bench sets the wanted level; the edge lands off the clock.
 */
`default_nettype none

module did_sensor (
   // requested and driven level
   input wire logic lvl,
   output logic comp
);
   timeunit 1ns;
   timeprecision 1ns;

   // lag 37 ns so edges never meet aclk; one driver, X until 37 ns
   assign #37 comp = lvl;
endmodule

`default_nettype wire

// [tb/did_props.sv]
/*
 * Port checker for did_top: bus handshakes and config commits.
 * Assumes one clock aclk and a synchronous active-low aresetn.
 */
`default_nettype none

module did_props (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus
   input wire logic awready,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   // analog config
   input wire logic [4:0] threshold_code,
   input wire logic threshold_reference_select,
   input wire logic sink_range,
   input wire logic [4:0] sink_code
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // -----------------------------------------------------------
   // bus
   // -----------------------------------------------------------
   a_bresp_hold: assert property (bvalid && !bready |=>
      bvalid && $stable(bresp)) else $error("write response dropped");
   a_rdata_hold: assert property (
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read response dropped");
   a_write_busy: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while response open");
   a_read_busy: assert property (rvalid |-> !arready)
      else $error("read taken while response open");
   a_err_zero: assert property (rvalid && rresp == did_pkg::RESP_SLVERR
      |-> rdata == 32'h0) else $error("error read carries data");

   // -----------------------------------------------------------
   // config outputs move only when a write commits
   // -----------------------------------------------------------
   a_code_commit: assert property (
      $changed(threshold_code) |-> $rose(bvalid))
      else $error("threshold code moved without write");
   a_ref_commit: assert property (
      $changed(threshold_reference_select) |-> $rose(bvalid))
      else $error("reference select moved without write");
   a_sink_commit: assert property (
      $changed({sink_range, sink_code}) |-> $rose(bvalid))
      else $error("sink setting moved without write");
endmodule

bind did_top did_props did_props_inst (.aclk(aclk), .aresetn(aresetn),
   .awready(awready), .wready(wready), .bvalid(bvalid), .bready(bready),
   .bresp(bresp), .arready(arready), .rvalid(rvalid), .rready(rready),
   .rdata(rdata), .rresp(rresp), .threshold_code(threshold_code),
   .threshold_reference_select(threshold_reference_select),
   .sink_range(sink_range), .sink_code(sink_code));

`default_nettype wire

// [tb/did_top_tb_top.sv]
/*
 * Self-checking bench for did_top over AXI4-Lite and the comparator.
 * Assumes TIME_SCALE_NS 100000, so code 10 needs 11 samples of 8 clocks.
 */
`default_nettype none

module did_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, lvl = 0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rd, rdata;
   logic [1:0] rr, br, bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, pin, tref, srng, comp;
   logic [4:0] tcode, scode;
   int errors = 0, n_checks = 0;

   did_top #(.TIME_SCALE_NS(100000)) did_top_inst (.aclk(aclk),
      .aresetn(aresetn), .ce(1'h1), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .comp_out_async(comp),
      .threshold_code(tcode), .threshold_reference_select(tref),
      .sink_range(srng), .sink_code(scode), .channel_output_pin(pin));
   did_sensor did_sensor_inst (.lvl(lvl), .comp(comp));

   // 100 ns clock
   initial forever #50 aclk = ~aclk;

   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   task automatic stop_test;
      if (errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // bready comes late so the response must stand
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge aclk);
      awvalid <= 1; wvalid <= 1; awaddr <= a; wdata <= d;
      forever begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if ((awready || !awvalid) && (wready || !wvalid)) break;
      end
      repeat (3) @(posedge aclk);
      bready <= 1;
      do @(posedge aclk); while (bvalid !== 1'h1);
      br = bresp; bready <= 0;
   endtask

   task automatic rdr(input logic [3:0] a);
      @(posedge aclk);
      arvalid <= 1; araddr <= a;
      do @(posedge aclk); while (arready !== 1'h1);
      arvalid <= 0;
      repeat (2) @(posedge aclk);
      rready <= 1;
      do @(posedge aclk); while (rvalid !== 1'h1);
      rd = rdata; rr = rresp; rready <= 0;
   endtask

   function automatic logic [31:0] mk(input logic [4:0] t,
      input logic s, v, c, input logic [1:0] o);
      return 32'(t) | 32'(s) << did_pkg::CFG_STYLE_BIT
         | 32'(v) << did_pkg::CFG_INVERT_BIT
         | 32'(c) << did_pkg::CFG_COUNTEN_BIT
         | 32'(o) << did_pkg::CFG_OUTSEL_LSB;
   endfunction

   task automatic wait_pin(input logic e, input int n);
      for (int k = 0; k < n && pin !== e; k++) @(posedge aclk);
      chk("pin", e, pin);
   endtask

   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   task automatic t_reset;
      rdr(did_pkg::ADDR_INPUT_CONFIG);
      chk("cfg", did_pkg::INPUT_CONFIG_RESET, rd);
      chk("resp", did_pkg::RESP_OKAY, rr);
      rdr(did_pkg::ADDR_EDGE_COUNT);
      chk("count", 32'h0, rd);
      rdr(4'h2);
      chk("bad resp", did_pkg::RESP_SLVERR, rr);
      wr(4'h2, 32'h0000_0001);
      chk("bad wr resp", did_pkg::RESP_SLVERR, br);
      wr(did_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
      chk("ro wr resp", did_pkg::RESP_OKAY, br);
      rdr(did_pkg::ADDR_STATUS);
      chk("ro status", 32'h0, rd);
   endtask

   // mid-run reset clears the count and the settings
   task automatic t_rereset;
      @(posedge aclk);
      aresetn <= 0;
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      rdr(did_pkg::ADDR_EDGE_COUNT);
      chk("count reset", 32'h0, rd);
      rdr(did_pkg::ADDR_THRESHOLD_SETUP);
      chk("thr reset", did_pkg::THRESHOLD_SETUP_RESET, rd);
      chk("pin reset", 32'h0, pin);
   endtask

   // recommended and boundary threshold / sink settings
   task automatic t_config;
      logic [4:0] tc[4] = '{5'h10, 5'h10, 5'h1D, 5'h1F};
      logic [4:0] sc[4] = '{5'h14, 5'h1D, 5'h00, 5'h1F};
      logic tr[4] = '{1, 1, 0, 1};
      logic sr[4] = '{0, 1, 0, 1};
      for (int i = 0; i < 4; i++) begin
         wr(did_pkg::ADDR_THRESHOLD_SETUP,
            32'(tr[i]) << did_pkg::THR_REFSEL_BIT | 32'(tc[i]));
         wr(did_pkg::ADDR_INPUT_CONFIG,
            32'(sr[i]) << did_pkg::CFG_SINKRANGE_BIT
            | 32'(sc[i]) << did_pkg::CFG_SINKCODE_LSB);
         chk("thr code", tc[i], tcode);
         chk("ref sel", tr[i], tref);
         chk("sink code", sc[i], scode);
         chk("sink range", sr[i], srng);
      end
   endtask

   // bypass, then the other pin sources
   task automatic t_bypass;
      logic [1:0] o[3] = '{2'h0, 2'h1, 2'h3};
      wr(did_pkg::ADDR_INPUT_CONFIG, mk(5'h00, 0, 0, 0, 2'h2));
      lvl <= 1;
      wait_pin(1, 30);
      rdr(did_pkg::ADDR_STATUS);
      chk("status", 32'h3, rd);
      for (int i = 0; i < 3; i++) begin
         wr(did_pkg::ADDR_INPUT_CONFIG, mk(5'h00, 0, 0, 0, o[i]));
         repeat (2) @(posedge aclk);
         chk("pin src", o[i] != 2'h0, pin);
      end
      wr(did_pkg::ADDR_INPUT_CONFIG, mk(5'h00, 0, 0, 0, 2'h2));
      lvl <= 0;
      wait_pin(0, 30);
   endtask

   // 7 high, 1 low, 9 high samples before the check, against target 11
   task automatic t_algo(input logic s);
      wr(did_pkg::ADDR_INPUT_CONFIG, mk(5'h10, s, 0, 0, 2'h2));
      lvl <= 1;
      repeat (56) @(posedge aclk);
      chk("early", 0, pin);
      lvl <= 0;
      repeat (8) @(posedge aclk);
      lvl <= 1;
      repeat (76) @(posedge aclk);
      chk("after glitch", !s, pin);
      wait_pin(1, 120);
      lvl <= 0;
      wait_pin(0, 150);
   endtask

   task automatic toggle;
      lvl <= 1;
      wait_pin(0, 40);
      lvl <= 0;
      wait_pin(1, 40);
   endtask

   // inverted input, count on, off, on again
   task automatic t_edges;
      wr(did_pkg::ADDR_INPUT_CONFIG, mk(5'h01, 0, 1, 0, 2'h2));
      wait_pin(1, 30);
      wr(did_pkg::ADDR_INPUT_CONFIG, mk(5'h01, 0, 1, 1, 2'h2));
      toggle();
      toggle();
      rdr(did_pkg::ADDR_EDGE_COUNT);
      chk("count", 32'h2, rd);
      wr(did_pkg::ADDR_INPUT_CONFIG, mk(5'h01, 0, 1, 0, 2'h2));
      toggle();
      rdr(did_pkg::ADDR_EDGE_COUNT);
      chk("frozen", 32'h2, rd);
      wr(did_pkg::ADDR_INPUT_CONFIG, mk(5'h01, 0, 1, 1, 2'h2));
      toggle();
      rdr(did_pkg::ADDR_EDGE_COUNT);
      chk("resumed", 32'h3, rd);
   endtask

   // main sequence
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      t_reset();
      t_config();
      t_bypass();
      t_algo(0);
      t_algo(1);
      t_edges();
      t_rereset();
      stop_test();
   end

   // hang guard, about twenty times the expected run
   initial begin
      #(20000 * 100);
      errors++;
      stop_test();
   end
endmodule

`default_nettype wire
